// ---- include/pmwt_pkg.sv ----
// constants shared by the power-management wake and trap register group
package pmwt_pkg;

   // ************
   // register indices (byte address is four times these)
   // ************
   localparam logic [7:0] PMWT_IDX_LEG_CTRL    = 8'h56;
   localparam logic [7:0] PMWT_IDX_SET_PORT    = 8'h58;
   localparam logic [7:0] PMWT_IDX_IRQ_WAKE_EN = 8'h5A;
   localparam logic [7:0] PMWT_IDX_SMI_ADDR    = 8'h5C;
   localparam logic [7:0] PMWT_IDX_SMI_CMD     = 8'h5E;
   localparam logic [7:0] PMWT_IDX_TW_CTRL     = 8'h5F;
   localparam logic [7:0] PMWT_IDX_WAKE_STS    = 8'h60;
   localparam logic [7:0] PMWT_IDX_WAKE_CTRL   = 8'h62;

   // ************
   // values after reset
   // ************
   localparam logic [15:0] PMWT_RST_IRQ_WAKE_EN = 16'h0000;
   localparam logic [15:0] PMWT_RST_SMI_ADDR    = 16'h0000;
   localparam logic [7:0]  PMWT_RST_SMI_CMD     = 8'h00;
   localparam logic [7:0]  PMWT_RST_TW_CTRL     = 8'h1F;
   localparam logic [15:0] PMWT_RST_WAKE_STS    = 16'h0000;
   localparam logic [7:0]  PMWT_RST_LEG_CTRL    = 8'h00;
   localparam logic [15:0] PMWT_RST_SET_PULSE   = 16'h0000;

   // ************
   // field positions
   // ************
   localparam int PMWT_BIT_SET_PORT_EN  = 7;  // legacy control
   localparam int PMWT_BIT_NMI_WAKE     = 2;  // interrupt wake enable
   localparam int PMWT_BIT_ALERT_LVL    = 4;  // two-wire control
   localparam int PMWT_BIT_DATA_LVL     = 3;
   localparam int PMWT_BIT_CLOCK_LVL    = 2;
   localparam int PMWT_BIT_DATA_DRIVE   = 1;
   localparam int PMWT_BIT_CLOCK_DRIVE  = 0;
   localparam int PMWT_BIT_WAKE_CLEAR   = 0;  // wake control
   localparam int PMWT_BIT_PWRBTN_WAKE  = 15; // wake status
   localparam int PMWT_BIT_ALARM_WAKE   = 14;
   localparam int PMWT_BIT_RING_WAKE    = 13;
   localparam int PMWT_BIT_NET_WAKE     = 12;
   localparam int PMWT_BIT_BUS_WAKE     = 11;
   localparam int PMWT_BIT_AUDIO_WAKE   = 10;
   localparam int PMWT_BIT_KBD_WAKE     = 9;
   localparam int PMWT_BIT_SERIAL_WAKE  = 8;
   localparam int PMWT_BIT_ALERT_WAKE   = 7;
   localparam int PMWT_BIT_RESUME_WAKE  = 6;
   localparam int PMWT_BIT_S3_ENTRY     = 1;

   // ************
   // bus answer codes
   // ************
   localparam logic [1:0] PMWT_RESP_OKAY  = 2'b00;
   localparam logic [1:0] PMWT_RESP_SLVER = 2'b10;

endpackage : pmwt_pkg

// ---- rtl/pmwt_sync.sv ----
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ns
module pmwt_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock_in,
   input  wire logic             reset_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;

   // first stage feeds only the second stage
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         meta_ff  <= '0;
         sync_out <= '0;
      end else begin
         meta_ff  <= async_in;
         sync_out <= meta_ff;
      end
   end

endmodule : pmwt_sync

// ---- rtl/pmwt_regs.sv ----
// power-management wake, smi trap and two-wire pin register group
`timescale 1ns/1ns
module pmwt_regs
   import pmwt_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        reset_in,
   // avalon-mm slave, address is the register index
   input  wire logic [7:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic      [1:0]  avs_response_out,
   output logic             avs_waitrequest_out,
   // legacy event status set strobes
   output logic      [15:0] legacy_status_set_out,
   // interrupt wake sources
   input  wire logic [15:0] irq_lines_in,
   input  wire logic        nmi_in,
   output logic             irq_wake_out,
   // processor i/o cycle monitor
   input  wire logic        io_cycle_valid_in,
   input  wire logic [15:0] io_address_in,
   input  wire logic [3:0]  io_command_in,
   input  wire logic [3:0]  io_byte_enable_in,
   input  wire logic        smi_entry_in,
   // two-wire pins, open drain
   input  wire logic        two_wire_alert_pin_n_in,
   input  wire logic        two_wire_data_pin_in,
   output logic             two_wire_data_pin_out,
   output logic             two_wire_data_pin_oe_out,
   input  wire logic        two_wire_clock_pin_in,
   output logic             two_wire_clock_pin_out,
   output logic             two_wire_clock_pin_oe_out,
   // sleep state and wake sources
   input  wire logic        sleep_s3_in,
   input  wire logic        sleep_s4_in,
   input  wire logic        sleep_s5_in,
   input  wire logic        standby_power_good_in,
   input  wire logic        power_button_wake_in,
   input  wire logic        clock_alarm_wake_in,
   input  wire logic        ring_wake_in,
   input  wire logic        network_pm_wake_in,
   input  wire logic        bus_pm_wake_in,
   input  wire logic        audio_pm_wake_in,
   input  wire logic        keyboard_wake_in,
   input  wire logic        serial_bus_wake_in,
   input  wire logic        alert_input_wake_in,
   input  wire logic        supply_resume_wake_in
);

   // ************
   // pin synchronisers
   // ************
   localparam int NSYNC = 34;

   logic [NSYNC-1:0] pins_async;
   logic [NSYNC-1:0] pins_sync;
   logic [15:0]      irq_sync;
   logic             nmi_sync;
   logic             alert_pin_level;
   logic             data_pin_level;
   logic             clock_pin_level;
   logic             s3_sync;
   logic             s4_sync;
   logic             s5_sync;
   logic             power_good_sync;
   logic [9:0]       source_sync;

   // gather all pin levels into one vector
   assign pins_async = {irq_lines_in, nmi_in, two_wire_alert_pin_n_in,
                        two_wire_data_pin_in, two_wire_clock_pin_in,
                        sleep_s3_in, sleep_s4_in, sleep_s5_in,
                        standby_power_good_in,
                        power_button_wake_in, clock_alarm_wake_in,
                        ring_wake_in, network_pm_wake_in, bus_pm_wake_in,
                        audio_pm_wake_in, keyboard_wake_in,
                        serial_bus_wake_in, alert_input_wake_in,
                        supply_resume_wake_in};

   pmwt_sync #(
      .WIDTH    (NSYNC)
   ) u_sync (
      .clock_in (clock_in),
      .reset_in (reset_in),
      .async_in (pins_async),
      .sync_out (pins_sync)
   );

   // split synchronised levels back out
   assign irq_sync        = pins_sync[33:18];
   assign nmi_sync        = pins_sync[17];
   assign alert_pin_level = pins_sync[16];
   assign data_pin_level  = pins_sync[15];
   assign clock_pin_level = pins_sync[14];
   assign s3_sync         = pins_sync[13];
   assign s4_sync         = pins_sync[12];
   assign s5_sync         = pins_sync[11];
   assign power_good_sync = pins_sync[10];
   assign source_sync     = pins_sync[9:0];

   // ************
   // bus handshake
   // ************
   logic        ack_ff;
   logic        bus_req;
   logic        wr_take;
   logic        rd_first;
   logic        hit;
   logic [1:0]  be_lo;

   assign bus_req  = avs_read_in | avs_write_in;
   assign wr_take  = avs_write_in & ack_ff;
   assign rd_first = avs_read_in & ~ack_ff;
   assign be_lo    = avs_byteenable_in[1:0];

   // wait request drops in the second cycle of each request
   assign avs_waitrequest_out = bus_req & ~ack_ff;

   // acknowledge toggles high for one cycle per request
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= bus_req & ~ack_ff;
      end
   end

   // decode a register index into a hit flag
   function automatic logic idx_hit(input logic [7:0] idx);
      return idx == PMWT_IDX_LEG_CTRL    || idx == PMWT_IDX_SET_PORT  ||
             idx == PMWT_IDX_IRQ_WAKE_EN || idx == PMWT_IDX_SMI_ADDR  ||
             idx == PMWT_IDX_SMI_CMD     || idx == PMWT_IDX_TW_CTRL   ||
             idx == PMWT_IDX_WAKE_STS    || idx == PMWT_IDX_WAKE_CTRL;
   endfunction : idx_hit

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [31:0] wd,
                                           input logic [1:0]  be);
      return {be[1] ? wd[15:8] : old_v[15:8],
              be[0] ? wd[7:0]  : old_v[7:0]};
   endfunction : merge16

   assign hit = idx_hit(avs_address_in);

   // ************
   // legacy control and set port
   // ************
   logic [7:0]  leg_ctrl_ff;
   logic [15:0] legacy_status_set_ff;
   logic [15:0] nxt_set_pulse;

   // only the set-port enable bit is kept here
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         leg_ctrl_ff <= PMWT_RST_LEG_CTRL;
      end else if (wr_take && avs_address_in == PMWT_IDX_LEG_CTRL &&
                   be_lo[0]) begin
         leg_ctrl_ff[PMWT_BIT_SET_PORT_EN] <=
            avs_writedata_in[PMWT_BIT_SET_PORT_EN];
      end
   end

   // ones written while enabled become one-cycle set strobes
   always_comb begin
      nxt_set_pulse = PMWT_RST_SET_PULSE;
      if (wr_take && avs_address_in == PMWT_IDX_SET_PORT &&
          leg_ctrl_ff[PMWT_BIT_SET_PORT_EN]) begin
         nxt_set_pulse = merge16(16'h0000, avs_writedata_in, be_lo);
      end
   end

   // set strobes registered for a clean output
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         legacy_status_set_ff <= PMWT_RST_SET_PULSE;
      end else begin
         legacy_status_set_ff <= nxt_set_pulse;
      end
   end

   assign legacy_status_set_out = legacy_status_set_ff;

   // ************
   // interrupt wake enable
   // ************
   logic [15:0] irq_wake_en_ff;
   logic [15:0] wake_lines;
   logic        irq_wake_ff;

   // enable register, byte-lane writable
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         irq_wake_en_ff <= PMWT_RST_IRQ_WAKE_EN;
      end else if (wr_take && avs_address_in == PMWT_IDX_IRQ_WAKE_EN) begin
         irq_wake_en_ff <= merge16(irq_wake_en_ff, avs_writedata_in, be_lo);
      end
   end

   // bit 2 watches the nmi, all others the same-numbered irq
   always_comb begin
      wake_lines                   = irq_sync;
      wake_lines[PMWT_BIT_NMI_WAKE] = nmi_sync;
   end

   // any enabled active line requests a wake-up
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         irq_wake_ff <= 1'b0;
      end else begin
         irq_wake_ff <= |(wake_lines & irq_wake_en_ff);
      end
   end

   assign irq_wake_out = irq_wake_ff;

   // ************
   // smi entry trap
   // ************
   logic [15:0] last_addr_ff;
   logic [7:0]  last_cmd_ff;
   logic [15:0] smi_addr_ff;
   logic [7:0]  smi_cmd_ff;

   // shadow of the most recent i/o cycle
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         last_addr_ff <= PMWT_RST_SMI_ADDR;
         last_cmd_ff  <= PMWT_RST_SMI_CMD;
      end else if (io_cycle_valid_in) begin
         last_addr_ff <= io_address_in;
         last_cmd_ff  <= {io_byte_enable_in, io_command_in};
      end
   end

   // freeze the shadow on smi entry; a same-cycle i/o cycle counts
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         smi_addr_ff <= PMWT_RST_SMI_ADDR;
         smi_cmd_ff  <= PMWT_RST_SMI_CMD;
      end else if (smi_entry_in) begin
         if (io_cycle_valid_in) begin
            smi_addr_ff <= io_address_in;
            smi_cmd_ff  <= {io_byte_enable_in, io_command_in};
         end else begin
            smi_addr_ff <= last_addr_ff;
            smi_cmd_ff  <= last_cmd_ff;
         end
      end
   end

   // ************
   // two-wire pin control
   // ************
   logic [1:0] pin_drive_ff;
   logic [7:0] tw_read;

   // drive bits reset to one so both pins float
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         pin_drive_ff <= PMWT_RST_TW_CTRL[1:0];
      end else if (wr_take && avs_address_in == PMWT_IDX_TW_CTRL &&
                   be_lo[0]) begin
         pin_drive_ff <= avs_writedata_in[1:0];
      end
   end

   // open drain: only ever pull low
   assign two_wire_data_pin_out     = 1'b0;
   assign two_wire_data_pin_oe_out  =
      ~pin_drive_ff[PMWT_BIT_DATA_DRIVE];
   assign two_wire_clock_pin_out    = 1'b0;
   assign two_wire_clock_pin_oe_out =
      ~pin_drive_ff[PMWT_BIT_CLOCK_DRIVE];

   // read image, reserved bits zero
   always_comb begin
      tw_read                      = 8'h00;
      tw_read[PMWT_BIT_ALERT_LVL]  = alert_pin_level;
      tw_read[PMWT_BIT_DATA_LVL]   = data_pin_level;
      tw_read[PMWT_BIT_CLOCK_LVL]  = clock_pin_level;
      tw_read[1:0]                 = pin_drive_ff;
   end

   // ************
   // wake source status
   // ************
   logic [15:0] wake_sts_ff;
   logic [15:0] wake_set;
   logic        asleep;
   logic        wake_clear;

   assign asleep     = s3_sync | s4_sync | s5_sync;
   assign wake_clear = wr_take && avs_address_in == PMWT_IDX_WAKE_CTRL &&
                       be_lo[0] && avs_writedata_in[PMWT_BIT_WAKE_CLEAR];

   // set terms from each wake source while asleep, the supply resume source only in S5
   always_comb begin
      wake_set = 16'h0000;
      wake_set[PMWT_BIT_PWRBTN_WAKE] = asleep & source_sync[9];
      wake_set[PMWT_BIT_ALARM_WAKE]  = asleep & source_sync[8];
      wake_set[PMWT_BIT_RING_WAKE]   = asleep & source_sync[7];
      wake_set[PMWT_BIT_NET_WAKE]    = asleep & source_sync[6];
      wake_set[PMWT_BIT_BUS_WAKE]    = asleep & source_sync[5];
      wake_set[PMWT_BIT_AUDIO_WAKE]  = asleep & source_sync[4];
      wake_set[PMWT_BIT_KBD_WAKE]    = asleep & source_sync[3];
      wake_set[PMWT_BIT_SERIAL_WAKE] = asleep & source_sync[2];
      wake_set[PMWT_BIT_ALERT_WAKE]  = asleep & source_sync[1];
      wake_set[PMWT_BIT_RESUME_WAKE] = s5_sync & source_sync[0];
      wake_set[PMWT_BIT_S3_ENTRY]    = s3_sync;
   end

   // power loss clears outright; a software clear loses to a set
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         wake_sts_ff <= PMWT_RST_WAKE_STS;
      end else if (!power_good_sync) begin
         wake_sts_ff <= PMWT_RST_WAKE_STS;
      end else if (wake_clear) begin
         wake_sts_ff <= wake_set;
      end else begin
         wake_sts_ff <= wake_sts_ff | wake_set;
      end
   end

   // ************
   // read data and response
   // ************
   logic [31:0] readdata_ff;
   logic [1:0]  response_ff;
   logic [31:0] nxt_readdata;

   // read multiplexer; write-only and clear ports read zero
   always_comb begin
      nxt_readdata = 32'h0000_0000;
      unique case (avs_address_in)
         PMWT_IDX_LEG_CTRL:    nxt_readdata[7:0]  = leg_ctrl_ff;
         PMWT_IDX_IRQ_WAKE_EN: nxt_readdata[15:0] = irq_wake_en_ff;
         PMWT_IDX_SMI_ADDR:    nxt_readdata[15:0] = smi_addr_ff;
         PMWT_IDX_SMI_CMD:     nxt_readdata[7:0]  = smi_cmd_ff;
         PMWT_IDX_TW_CTRL:     nxt_readdata[7:0]  = tw_read;
         PMWT_IDX_WAKE_STS:    nxt_readdata[15:0] = wake_sts_ff;
         default:              nxt_readdata       = 32'h0000_0000;
      endcase
   end

   // data and response captured in the wait cycle
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         readdata_ff <= 32'h0000_0000;
         response_ff <= PMWT_RESP_OKAY;
      end else if (bus_req && !ack_ff) begin
         readdata_ff <= rd_first ? nxt_readdata : 32'h0000_0000;
         response_ff <= hit ? PMWT_RESP_OKAY : PMWT_RESP_SLVER;
      end
   end

   assign avs_readdata_out = readdata_ff;
   assign avs_response_out = response_ff;

endmodule : pmwt_regs

// ---- tb/pmwt_regs_monitor.sv ----
// checker of set pulses, trap capture and pin drive of the register group
`timescale 1ns/1ns
module pmwt_regs_monitor
   import pmwt_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        reset_in,
   input  wire logic [7:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   input  wire logic [31:0] avs_readdata_out,
   input  wire logic        avs_waitrequest_out,
   input  wire logic [15:0] legacy_status_set_out,
   input  wire logic        io_cycle_valid_in,
   input  wire logic [15:0] io_address_in,
   input  wire logic [3:0]  io_command_in,
   input  wire logic [3:0]  io_byte_enable_in,
   input  wire logic        smi_entry_in,
   input  wire logic        two_wire_data_pin_oe_out,
   input  wire logic        two_wire_clock_pin_oe_out
);
   // ************
   // shadow logic
   // ************
   default clocking mon_cb @(posedge clock_in);
   endclocking
   default disable iff (reset_in);
   logic        wr_ok, rd_ok, set_wr, tw_wr, en_ff;
   logic [15:0] lane;
   logic [23:0] io_now, last_ff, cap_ff;
   // taken transfers and the lane-masked write value
   assign wr_ok  = avs_write_in && !avs_waitrequest_out;
   assign rd_ok  = avs_read_in && !avs_waitrequest_out;
   assign set_wr = wr_ok && avs_address_in == PMWT_IDX_SET_PORT;
   assign tw_wr  = wr_ok && avs_address_in == PMWT_IDX_TW_CTRL
                   && avs_byteenable_in[0];
   assign lane   = avs_writedata_in[15:0] & {{8{avs_byteenable_in[1]}},
                                             {8{avs_byteenable_in[0]}}};
   assign io_now = {io_byte_enable_in, io_command_in, io_address_in};
   // set-port enable as last written
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in)
         en_ff <= 1'b0;
      else if (wr_ok && avs_address_in == PMWT_IDX_LEG_CTRL
               && avs_byteenable_in[0])
         en_ff <= avs_writedata_in[PMWT_BIT_SET_PORT_EN];
   end
   // last i/o cycle and its copy at trap entry, same-cycle cycle wins
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         last_ff <= 24'h000000;
         cap_ff  <= 24'h000000;
      end else begin
         if (io_cycle_valid_in)
            last_ff <= io_now;
         if (smi_entry_in)
            cap_ff <= io_cycle_valid_in ? io_now : last_ff;
      end
   end
   AST_SET_PULSE: assert property (set_wr |=>
      legacy_status_set_out == ($past(en_ff) ? $past(lane) : 16'h0000))
      else $error("bad set pulse");
   AST_SET_QUIET: assert property (|legacy_status_set_out |->
      $past(set_wr) && $past(en_ff))
      else $error("stray set pulse");
   AST_SMI_ADDR: assert property (rd_ok &&
      avs_address_in == PMWT_IDX_SMI_ADDR |->
      avs_readdata_out[15:0] == $past(cap_ff[15:0]))
      else $error("bad trap address");
   AST_SMI_BE: assert property (rd_ok &&
      avs_address_in == PMWT_IDX_SMI_CMD |->
      avs_readdata_out[7:4] == $past(cap_ff[23:20]))
      else $error("bad trap byte enables");
   AST_SMI_CMD: assert property (rd_ok &&
      avs_address_in == PMWT_IDX_SMI_CMD |->
      avs_readdata_out[3:0] == $past(cap_ff[19:16]))
      else $error("bad trap command");
   AST_DATA_DRIVE: assert property (tw_wr |=>
      two_wire_data_pin_oe_out == !$past(avs_writedata_in[1]))
      else $error("data pin pull-down wrong");
   AST_CLOCK_DRIVE: assert property (tw_wr |=>
      two_wire_clock_pin_oe_out == !$past(avs_writedata_in[0]))
      else $error("clock pin pull-down wrong");
   AST_OE_RESET: assert property ($fell(reset_in) |->
      !two_wire_data_pin_oe_out && !two_wire_clock_pin_oe_out)
      else $error("pin pulled low after reset");
   cover property (set_wr && en_ff);
   cover property (smi_entry_in && io_cycle_valid_in);
   cover property (tw_wr && avs_writedata_in[1:0] == 2'b10);
endmodule : pmwt_regs_monitor

// ---- tb/pmwt_two_wire_model.sv ----
// open-drain two-wire bus with pull-ups and one remote device
`timescale 1ns/1ns
module pmwt_two_wire_model (
   input  wire logic data_oe_in,
   input  wire logic clock_oe_in,
   input  wire logic remote_data_low_in,
   input  wire logic remote_alert_in,
   output logic      data_level_out,
   output logic      clock_level_out,
   output logic      alert_level_n_out
);
   // wired-and of every pull-down against the pull-ups
   assign data_level_out    = !(data_oe_in || remote_data_low_in);
   assign clock_level_out   = !clock_oe_in;
   assign alert_level_n_out = !remote_alert_in;
endmodule : pmwt_two_wire_model

// ---- tb/test_pm_wake_trap_regs.sv ----
// self-checking bench for the wake and trap register group
`timescale 1ns/1ns
module test_pm_wake_trap_regs import pmwt_pkg::*;;
   logic clock_in, reset_in, avs_read_in, avs_write_in, nmi_in, far_alert;
   logic io_cycle_valid_in, smi_entry_in, sleep_s3_in, sleep_s4_in;
   logic sleep_s5_in, standby_power_good_in, far_data_low, irq_wake_out;
   logic avs_waitrequest_out, two_wire_data_pin_out, two_wire_clock_pin_out;
   logic two_wire_data_pin_oe_out, two_wire_clock_pin_oe_out;
   logic two_wire_alert_pin_n_in, two_wire_data_pin_in, two_wire_clock_pin_in;
   logic [7:0]  avs_address_in;
   logic [31:0] avs_writedata_in, avs_readdata_out, rdata;
   logic [3:0]  avs_byteenable_in, io_command_in, io_byte_enable_in;
   logic [1:0]  avs_response_out, rresp;
   logic [15:0] irq_lines_in, io_address_in, legacy_status_set_out, seen;
   logic [9:0]  src;
   int          failures, compares;
   pmwt_regs dut (.clock_in, .reset_in, .avs_address_in, .avs_read_in,
      .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
      .avs_response_out, .avs_waitrequest_out, .legacy_status_set_out,
      .irq_lines_in, .nmi_in, .irq_wake_out, .io_cycle_valid_in,
      .io_address_in, .io_command_in, .io_byte_enable_in, .smi_entry_in,
      .two_wire_alert_pin_n_in, .two_wire_data_pin_in, .two_wire_data_pin_out,
      .two_wire_data_pin_oe_out, .two_wire_clock_pin_in,
      .two_wire_clock_pin_out, .two_wire_clock_pin_oe_out, .sleep_s3_in,
      .sleep_s4_in, .sleep_s5_in, .standby_power_good_in,
      .power_button_wake_in(src[9]), .clock_alarm_wake_in(src[8]),
      .ring_wake_in(src[7]), .network_pm_wake_in(src[6]),
      .bus_pm_wake_in(src[5]), .audio_pm_wake_in(src[4]),
      .keyboard_wake_in(src[3]), .serial_bus_wake_in(src[2]),
      .alert_input_wake_in(src[1]), .supply_resume_wake_in(src[0]));
   pmwt_two_wire_model far (.data_oe_in(two_wire_data_pin_oe_out),
      .clock_oe_in(two_wire_clock_pin_oe_out),
      .remote_data_low_in(far_data_low), .remote_alert_in(far_alert),
      .data_level_out(two_wire_data_pin_in),
      .clock_level_out(two_wire_clock_pin_in),
      .alert_level_n_out(two_wire_alert_pin_n_in));
   // one bus transfer, held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [15:0] d, input logic [1:0] b);
      int n = 0;
      @(posedge clock_in);
      avs_address_in <= a;
      avs_writedata_in <= {16'h0000, d};
      avs_byteenable_in <= {2'b00, b};
      avs_read_in <= !w;
      avs_write_in <= w;
      do @(posedge clock_in);
      while (avs_waitrequest_out !== 1'b0 && ++n < 50);
      if (avs_waitrequest_out !== 1'b0) failures++;
      rdata = avs_readdata_out;
      rresp = avs_response_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask : bus
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 16'h0000, 2'b11);
      chk(rdata, exp);
   endtask : rdc
   task automatic report_and_stop;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   // clock and watchdog
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   initial begin
      #200000;
      failures++;
      report_and_stop();
   end
   // gather every set pulse seen
   always @(posedge clock_in)
      if (!reset_in && legacy_status_set_out !== 16'h0000)
         seen <= seen | legacy_status_set_out;
   // ************
   // test sequence
   // ************
   initial begin
      logic [15:0] acc;
      {avs_read_in, avs_write_in, nmi_in, far_alert, far_data_low} = 5'h00;
      {io_cycle_valid_in, smi_entry_in, sleep_s3_in, sleep_s4_in} = 4'h0;
      {sleep_s5_in, avs_address_in, avs_writedata_in} = 41'h0;
      {avs_byteenable_in, io_command_in, io_byte_enable_in, src} = 22'h0;
      {irq_lines_in, io_address_in, seen, acc} = 64'h0;
      standby_power_good_in = 1'b1;
      failures = 0;
      compares = 0;
      reset_in = 1'b1;
      repeat (10) @(posedge clock_in);
      reset_in <= 1'b0;
      repeat (3) @(posedge clock_in);
      rdc(PMWT_IDX_IRQ_WAKE_EN, 32'h0);
      rdc(PMWT_IDX_SMI_CMD, 32'h0);
      rdc(PMWT_IDX_TW_CTRL, 32'h1F);
      rdc(PMWT_IDX_WAKE_STS, 32'h0);
      rdc(8'h40, 32'h0);
      chk({30'h0, rresp}, {30'h0, PMWT_RESP_SLVER});
      // set port refused while disabled, then lane by lane
      bus(1'b1, PMWT_IDX_SET_PORT, 16'hFFFF, 2'b11);
      bus(1'b1, PMWT_IDX_LEG_CTRL, 16'h0080, 2'b01);
      bus(1'b1, PMWT_IDX_SET_PORT, 16'hA5C3, 2'b01);
      bus(1'b1, PMWT_IDX_SET_PORT, 16'h5A00, 2'b10);
      repeat (2) @(posedge clock_in);
      chk({16'h0000, seen}, 32'h00005AC3);
      for (int k = 0; k < 16; k++) begin
         bus(1'b1, PMWT_IDX_IRQ_WAKE_EN, 16'h0001 << k, 2'b11);
         {nmi_in, irq_lines_in} <= (k == 2) ? 17'h0FFFF
                                   : {1'b1, ~(16'h0001 << k)};
         repeat (5) @(posedge clock_in);
         chk({31'h0, irq_wake_out}, 32'h0);
         {nmi_in, irq_lines_in} <= (k == 2) ? 17'h10000
                                   : {1'b0, 16'h0001 << k};
         repeat (5) @(posedge clock_in);
         chk({31'h0, irq_wake_out}, 32'h1);
      end
      // trap: earlier cycle, same-cycle cycle, later cycle ignored
      {io_cycle_valid_in, io_address_in} <= 17'h103F8;
      {io_byte_enable_in, io_command_in} <= 8'hE2;
      @(posedge clock_in);
      {io_cycle_valid_in, smi_entry_in} <= 2'b01;
      @(posedge clock_in);
      smi_entry_in <= 1'b0;
      rdc(PMWT_IDX_SMI_ADDR, 32'h03F8);
      rdc(PMWT_IDX_SMI_CMD, 32'hE2);
      {io_cycle_valid_in, smi_entry_in, io_address_in} <= 18'h30CF9;
      {io_byte_enable_in, io_command_in} <= 8'h73;
      @(posedge clock_in);
      {io_cycle_valid_in, smi_entry_in, io_address_in} <= 18'h21234;
      @(posedge clock_in);
      io_cycle_valid_in <= 1'b0;
      bus(1'b1, PMWT_IDX_SMI_ADDR, 16'hFFFF, 2'b11);
      rdc(PMWT_IDX_SMI_ADDR, 32'h0CF9);
      rdc(PMWT_IDX_SMI_CMD, 32'h73);
      // pin pull-downs against the remote device
      bus(1'b1, PMWT_IDX_TW_CTRL, 16'h0000, 2'b01);
      repeat (4) @(posedge clock_in);
      rdc(PMWT_IDX_TW_CTRL, 32'h10);
      bus(1'b1, PMWT_IDX_TW_CTRL, 16'h0002, 2'b01);
      far_alert <= 1'b1;
      repeat (4) @(posedge clock_in);
      rdc(PMWT_IDX_TW_CTRL, 32'h0A);
      far_data_low <= 1'b1;
      bus(1'b1, PMWT_IDX_TW_CTRL, 16'h00FF, 2'b01);
      repeat (4) @(posedge clock_in);
      rdc(PMWT_IDX_TW_CTRL, 32'h07);
      // wake sources from S5, one by one, sticky
      sleep_s5_in <= 1'b1;
      for (int k = 0; k < 10; k++) begin
         src <= 10'h001 << k;
         acc = acc | (16'h0040 << k);
         repeat (5) @(posedge clock_in);
         rdc(PMWT_IDX_WAKE_STS, {16'h0, acc});
      end
      {src, sleep_s5_in} <= 11'h000;
      repeat (5) @(posedge clock_in);
      rdc(PMWT_IDX_WAKE_STS, {16'h0, acc});
      bus(1'b1, PMWT_IDX_WAKE_CTRL, 16'h0001, 2'b01);
      rdc(PMWT_IDX_WAKE_STS, 32'h0);
      {src, sleep_s4_in} <= 11'h403;
      repeat (5) @(posedge clock_in);
      rdc(PMWT_IDX_WAKE_STS, 32'h8000);
      {src, sleep_s4_in, sleep_s3_in} <= 12'h001;
      repeat (5) @(posedge clock_in);
      rdc(PMWT_IDX_WAKE_STS, 32'h8002);
      {sleep_s3_in, standby_power_good_in} <= 2'b00;
      repeat (5) @(posedge clock_in);
      standby_power_good_in <= 1'b1;
      repeat (5) @(posedge clock_in);
      rdc(PMWT_IDX_WAKE_STS, 32'h0);
      report_and_stop();
   end
endmodule : test_pm_wake_trap_regs
bind pmwt_regs pmwt_regs_monitor mon (.clock_in, .reset_in, .avs_address_in,
   .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
   .avs_readdata_out, .avs_waitrequest_out, .legacy_status_set_out,
   .io_cycle_valid_in, .io_address_in, .io_command_in, .io_byte_enable_in,
   .smi_entry_in, .two_wire_data_pin_oe_out, .two_wire_clock_pin_oe_out);
